// ==== rtl/i2c_event_flag_bits.sv ====
// Event flag logic for I2C event bits 5 through 22
`timescale 1ns/1ps
module i2c_event_flag_bits
  import i2c_event_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic soft_reset_bit,
  input wire logic [EVW-1:0] wr_data,
  input wire logic event_clear_wr,
  input wire logic snap_clear_wr,
  input wire logic new_set_wr,
  input wire logic int_status_rd,
  input wire logic diag_timer_expiry,
  input wire logic diag_history_record,
  input wire logic diag_command_done,
  input wire logic in_mailbox_written,
  input wire logic out_mailbox_read,
  input wire logic out_mailbox_full_flag,
  input wire logic slave_ext_active,
  input wire logic slave_collision,
  input wire logic slave_txn_timeout,
  input wire logic slave_byte_timeout,
  input wire logic slave_clock_low_timeout,
  input wire logic master_txn_done,
  input wire logic boot_load_active,
  input wire logic boot_nack_error,
  input wire logic boot_scl_low_error,
  input wire logic boot_collision_error,
  input wire logic boot_tail_valid,
  input wire logic [7:0] boot_tail_byte,
  input wire logic boot_count_invalid,
  input wire logic [WADDR_W-1:0] boot_count_value,
  input wire logic boot_read_valid,
  input wire logic [WADDR_W-1:0] boot_eeprom_addr,
  input wire logic [WDATA_W-1:0] boot_eeprom_data,
  input wire logic boot_addr_nack,
  input wire logic boot_addr_ack,
  output logic [EVW-1:0] event_flags,
  output logic [EVW-1:0] snap_flags,
  output logic [EVW-1:0] new_flags,
  output logic [WADDR_W-1:0] boot_last_write_address,
  output logic [WDATA_W-1:0] boot_last_write_data,
  output logic master_nack_received,
  output logic master_collision,
  output logic master_clock_low_timeout
);

  state_type s_r;
  state_type s_nxt;
  logic [EVW-1:0] set_vec;
  logic [EVW-1:0] ev_clr;
  logic [EVW-1:0] sn_clr;
  logic [EVW-1:0] new_kept;
  logic hist_full;
  logic nodev_hit;
  logic tail_bad;
  logic boot_err;

  assign hist_full = diag_history_record && (s_r.hist_cnt == HIST_EVENTS - 4'h1);
  assign nodev_hit = boot_load_active && boot_addr_nack
                     && (s_r.nack_cnt == NODEV_TRIES - 3'h1);
  assign tail_bad = boot_tail_valid && (boot_tail_byte != COUNT_TAIL_BYTE);
  assign boot_err = boot_load_active
                    && (boot_nack_error || boot_scl_low_error
                        || boot_collision_error || tail_bad);

  // Hardware set conditions, one term per event bit; the four boot faults share one bit
  always_comb begin
    set_vec = '0;
    set_vec[BIT_DIAG_TIMER] = diag_timer_expiry && !boot_load_active;
    set_vec[BIT_BOOT_TO] = diag_timer_expiry && boot_load_active;
    set_vec[BIT_DIAG_HIST] = hist_full;
    set_vec[BIT_DIAG_CMD] = diag_command_done;
    set_vec[BIT_IN_MBOX] = in_mailbox_written;
    set_vec[BIT_OUT_MBOX] = out_mailbox_read && out_mailbox_full_flag;
    // Slave faults only count inside a transaction an external master began
    set_vec[BIT_SLV_COL] = slave_ext_active && slave_collision;
    set_vec[BIT_SLV_TXN_TO] = slave_ext_active && slave_txn_timeout;
    set_vec[BIT_SLV_BYTE_TO] = slave_ext_active && slave_byte_timeout;
    set_vec[BIT_SLV_SCL_TO] = slave_ext_active && slave_clock_low_timeout;
    set_vec[BIT_MST_DONE] = master_txn_done;
    set_vec[BIT_BOOT_ERR] = boot_err;
    set_vec[BIT_BOOT_SIZE] = boot_load_active && boot_count_invalid;
    set_vec[BIT_BOOT_NODEV] = nodev_hit;
  end

  assign ev_clr = event_clear_wr ? wr_data : '0;
  assign sn_clr = snap_clear_wr ? wr_data : '0;
  assign new_kept = s_r.new_ev & ~ev_clr;

  always_comb begin
    s_nxt = s_r;
    // Clears act first, sets last, so an event in the clearing cycle survives
    s_nxt.snap_ev = s_r.snap_ev & ~ev_clr & ~sn_clr;
    s_nxt.new_ev = new_kept;
    if (int_status_rd) begin
      s_nxt.snap_ev = s_nxt.snap_ev | new_kept;
      s_nxt.new_ev = '0;
    end
    if (new_set_wr) begin
      s_nxt.new_ev = s_nxt.new_ev | wr_data;
    end
    s_nxt.new_ev = (s_nxt.new_ev | set_vec) & IMPL_MASK;
    s_nxt.snap_ev = s_nxt.snap_ev & IMPL_MASK;

    // History counter wraps after the eighth record
    if (diag_history_record) begin
      s_nxt.hist_cnt = hist_full ? 4'h0 : s_r.hist_cnt + 4'h1;
    end

    // Address NACK tally restarts on any ack or outside boot load
    if (!boot_load_active || boot_addr_ack) begin
      s_nxt.nack_cnt = 3'h0;
    end else if (boot_addr_nack) begin
      s_nxt.nack_cnt = nodev_hit ? 3'h0 : s_r.nack_cnt + 3'h1;
    end

    // Cause qualifiers pulse with the boot error
    s_nxt.q_nack = boot_load_active && boot_nack_error;
    s_nxt.q_col = boot_load_active && boot_collision_error;
    s_nxt.q_scl = boot_load_active && boot_scl_low_error;

    // Last EEPROM word stays visible; a bad count overrides the address
    if (boot_read_valid) begin
      s_nxt.waddr = boot_eeprom_addr;
      s_nxt.wdata = boot_eeprom_data;
    end
    if (boot_load_active && boot_count_invalid) begin
      s_nxt.waddr = boot_count_value;
    end

    // Soft reset clears flags and counters but keeps the boot trace words
    if (soft_reset_bit) begin
      s_nxt.new_ev = EVENT_RESET;
      s_nxt.snap_ev = EVENT_RESET;
      s_nxt.hist_cnt = 4'h0;
      s_nxt.nack_cnt = 3'h0;
      s_nxt.q_nack = 1'b0;
      s_nxt.q_col = 1'b0;
      s_nxt.q_scl = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= STATE_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign event_flags = s_r.new_ev | s_r.snap_ev;
  assign snap_flags = s_r.snap_ev;
  assign new_flags = s_r.new_ev;
  assign boot_last_write_address = s_r.waddr;
  assign boot_last_write_data = s_r.wdata;
  assign master_nack_received = s_r.q_nack;
  assign master_collision = s_r.q_col;
  assign master_clock_low_timeout = s_r.q_scl;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_diag_timer_expired_sets_flag: assert property (
    diag_timer_expiry && !boot_load_active && !soft_reset_bit
    |=> event_flags[BIT_DIAG_TIMER])
    else $error("diagnostic timer expiry did not set its flag");

  a_diag_timer_expired_w1c_clears: assert property (
    event_clear_wr && wr_data[BIT_DIAG_TIMER] && !new_set_wr
    && !set_vec[BIT_DIAG_TIMER] |=> !event_flags[BIT_DIAG_TIMER])
    else $error("diagnostic timer flag not cleared by write one");

  a_boot_timer_route: assert property (
    diag_timer_expiry && boot_load_active && !soft_reset_bit
    && !(new_set_wr && wr_data[BIT_DIAG_TIMER]) && !new_flags[BIT_DIAG_TIMER]
    |=> event_flags[BIT_BOOT_TO] && !new_flags[BIT_DIAG_TIMER])
    else $error("timer expiry in boot load not routed to boot timeout");

  a_boot_to_only_boot: assert property (
    !new_flags[BIT_BOOT_TO] && !boot_load_active
    && !(new_set_wr && wr_data[BIT_BOOT_TO]) |=> !new_flags[BIT_BOOT_TO])
    else $error("boot timeout flag rose outside boot load");

  a_hist_eighth: assert property (
    diag_history_record && !soft_reset_bit
    ##1 (diag_history_record && !soft_reset_bit) [*7]
    ##0 $past(s_r.hist_cnt, 7) == 4'h0
    |=> event_flags[BIT_DIAG_HIST])
    else $error("eighth history record did not set history flag");

  a_omb_empty_quiet: assert property (
    !new_flags[BIT_OUT_MBOX] && !out_mailbox_full_flag
    && !(new_set_wr && wr_data[BIT_OUT_MBOX]) |=> !new_flags[BIT_OUT_MBOX])
    else $error("read of empty outgoing mailbox raised an event");

  a_slave_col_sets: assert property (
    slave_ext_active && slave_collision && !soft_reset_bit
    |=> event_flags[BIT_SLV_COL])
    else $error("slave collision did not set its flag");

  a_nodev_six: assert property (
    (boot_load_active && boot_addr_nack && !boot_addr_ack && !soft_reset_bit
     && s_r.nack_cnt == 3'h0) ##1
    (boot_load_active && boot_addr_nack && !boot_addr_ack && !soft_reset_bit) [*5]
    |=> new_flags[BIT_BOOT_NODEV] || snap_flags[BIT_BOOT_NODEV])
    else $error("six address nacks did not raise no device flag");

  a_boot_err_cause: assert property (
    boot_load_active && boot_nack_error && !soft_reset_bit
    |=> master_nack_received && event_flags[BIT_BOOT_ERR])
    else $error("boot error missing its nack cause flag");

  a_size_addr: assert property (
    boot_load_active && boot_count_invalid && !soft_reset_bit
    |=> boot_last_write_address == $past(boot_count_value)
        && event_flags[BIT_BOOT_SIZE])
    else $error("size error did not expose the register count");

  a_snapshot_move: assert property (
    int_status_rd && !event_clear_wr && !snap_clear_wr && !soft_reset_bit
    |=> snap_flags == (($past(snap_flags) | $past(new_flags)) & IMPL_MASK))
    else $error("status read did not move new events to snapshot");

  a_soft_reset_hold: assert property (
    soft_reset_bit |=> event_flags == EVENT_RESET)
    else $error("flags not held clear under soft reset");

  a_reserved_zero: assert property (
    (event_flags & ~IMPL_MASK) == '0)
    else $error("reserved event bit read as one");

  a_set_beats_clear: assert property (
    master_txn_done && event_clear_wr && wr_data[BIT_MST_DONE] && !soft_reset_bit
    |=> event_flags[BIT_MST_DONE])
    else $error("same cycle clear dropped a master done event");

  c_boot_error: cover property (
    boot_load_active && boot_err ##1 event_flags[BIT_BOOT_ERR]);

  c_snapshot_then_clear: cover property (
    int_status_rd ##1 snap_flags != '0 ##[1:4] snap_clear_wr);

  c_nodev_reached: cover property (nodev_hit);

  c_mailbox_pair: cover property (
    in_mailbox_written ##[1:10] out_mailbox_read && out_mailbox_full_flag);

endmodule

// ==== rtl/i2c_event_pkg.sv ====
// Constants and state type for the I2C event flag logic
package i2c_event_pkg;

  localparam int EVW = 32;
  localparam int WADDR_W = 16;
  localparam int WDATA_W = 8;

  // Event bit positions
  localparam int BIT_DIAG_TIMER = 5;
  localparam int BIT_DIAG_HIST = 6;
  localparam int BIT_DIAG_CMD = 7;
  localparam int BIT_IN_MBOX = 8;
  localparam int BIT_OUT_MBOX = 9;
  localparam int BIT_SLV_COL = 11;
  localparam int BIT_SLV_TXN_TO = 12;
  localparam int BIT_SLV_BYTE_TO = 13;
  localparam int BIT_SLV_SCL_TO = 14;
  localparam int BIT_MST_DONE = 17;
  localparam int BIT_BOOT_TO = 19;
  localparam int BIT_BOOT_ERR = 20;
  localparam int BIT_BOOT_SIZE = 21;
  localparam int BIT_BOOT_NODEV = 22;

  // Implemented bits 5..9, 11..14, 17, 19..22; all others read zero
  localparam logic [EVW-1:0] IMPL_MASK = 32'h007a_7be0;
  localparam logic [EVW-1:0] EVENT_RESET = 32'h0000_0000;

  // Counts
  localparam logic [3:0] HIST_EVENTS = 4'h8;
  localparam logic [2:0] NODEV_TRIES = 3'h6;
  localparam logic [7:0] COUNT_TAIL_BYTE = 8'hff;

  typedef struct packed {
    logic [EVW-1:0] new_ev;
    logic [EVW-1:0] snap_ev;
    logic [3:0] hist_cnt;
    logic [2:0] nack_cnt;
    logic [WADDR_W-1:0] waddr;
    logic [WDATA_W-1:0] wdata;
    logic q_nack;
    logic q_col;
    logic q_scl;
  } state_type;

  localparam state_type STATE_RESET = '0;

endpackage

// ==== testbench/i2c_far_side_model.sv ====
// Far-side model: event strobes of the master, slave and boot sequencer
`timescale 1ns/1ps
module i2c_far_side_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [17:0] req,
  output logic [17:0] pulse
);
  // Registered, so each strobe repeats its request one cycle later and lasts as many cycles as the request does
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pulse <= '0;
    end else begin
      pulse <= req;
    end
  end
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench for the I2C event flag bits
`timescale 1ns/1ps
module tb;
  import i2c_event_pkg::*;
  logic clk, rst_n, srst, ec, sc, ns, rd, full, ext, boot, qn, qc, qs;
  logic [EVW-1:0] wd, ev, sn, nw;
  logic [17:0] req, p;
  logic [7:0] tail;
  logic [WADDR_W-1:0] cnt, ea, la;
  logic [WDATA_W-1:0] ed, ld;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  i2c_far_side_model i2c_far_side_model_i (.clk(clk), .rst_n(rst_n), .req(req), .pulse(p));

  i2c_event_flag_bits i2c_event_flag_bits_i (
    .clk(clk), .rst_n(rst_n), .soft_reset_bit(srst), .wr_data(wd), .event_clear_wr(ec),
    .snap_clear_wr(sc), .new_set_wr(ns), .int_status_rd(rd), .diag_timer_expiry(p[0]),
    .diag_history_record(p[1]), .diag_command_done(p[2]), .in_mailbox_written(p[3]),
    .out_mailbox_read(p[4]), .out_mailbox_full_flag(full), .slave_ext_active(ext),
    .slave_collision(p[5]), .slave_txn_timeout(p[6]), .slave_byte_timeout(p[7]),
    .slave_clock_low_timeout(p[8]), .master_txn_done(p[9]), .boot_load_active(boot),
    .boot_nack_error(p[10]), .boot_scl_low_error(p[11]), .boot_collision_error(p[12]),
    .boot_tail_valid(p[13]), .boot_tail_byte(tail), .boot_count_invalid(p[14]),
    .boot_count_value(cnt), .boot_read_valid(p[15]), .boot_eeprom_addr(ea),
    .boot_eeprom_data(ed), .boot_addr_nack(p[16]), .boot_addr_ack(p[17]),
    .event_flags(ev), .snap_flags(sn), .new_flags(nw), .boot_last_write_address(la),
    .boot_last_write_data(ld), .master_nack_received(qn), .master_collision(qc),
    .master_clock_low_timeout(qs));

  task automatic end_sim();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [EVW-1:0] seen, input logic [EVW-1:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Levels go up with the request, so they are settled when the strobe is taken
  task automatic fire(input int idx, input logic b, input logic e, input logic f);
    @(posedge clk) req <= 18'h1 << idx;
    boot <= b;
    ext <= e;
    full <= f;
    @(posedge clk) req <= '0;
    @(posedge clk) #1;
  endtask

  task automatic sw(input logic e, input logic s, input logic n, input logic r,
                    input logic [EVW-1:0] d);
    @(posedge clk) {ec, sc, ns, rd} <= {e, s, n, r};
    wd <= d;
    @(posedge clk) {ec, sc, ns, rd} <= 4'h0;
    #1;
  endtask

  // Fires one source, compares flags and cause pulses, then clears every event flag
  task automatic hit(input int idx, input logic b, input logic e, input logic f,
                     input logic [EVW-1:0] exp, input logic [2:0] q);
    fire(idx, b, e, f);
    chk(ev, exp);
    chk({29'h0, qn, qc, qs}, {29'h0, q});
    sw(1'b1, 1'b0, 1'b0, 1'b0, '1);
    chk(ev, 32'h0);
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 5000) begin
      num_errors++;
      end_sim();
    end
  end

  initial begin
    {rst_n, srst, ec, sc, ns, rd, full, ext, boot} = '0;
    {wd, req, tail, cnt, ea, ed} = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk(ev, EVENT_RESET);
    hit(0, 0, 0, 0, 32'h20, 3'h0);
    hit(0, 1, 0, 0, 32'h80000, 3'h0);
    hit(2, 0, 0, 0, 32'h80, 3'h0);
    hit(3, 0, 0, 0, 32'h100, 3'h0);
    hit(4, 0, 0, 1, 32'h200, 3'h0);
    hit(4, 0, 0, 0, 32'h0, 3'h0);
    hit(5, 0, 1, 0, 32'h800, 3'h0);
    hit(5, 0, 0, 0, 32'h0, 3'h0);
    hit(6, 0, 1, 0, 32'h1000, 3'h0);
    hit(7, 0, 1, 0, 32'h2000, 3'h0);
    hit(8, 0, 1, 0, 32'h4000, 3'h0);
    hit(9, 0, 0, 0, 32'h20000, 3'h0);
    hit(10, 0, 0, 0, 32'h0, 3'h0);
    $display("single sources done");
    @(posedge clk) ea <= 16'h1234;
    ed <= 8'h5a;
    tail <= 8'h00;
    fire(15, 1, 0, 0);
    hit(10, 1, 0, 0, 32'h100000, 3'h4);
    hit(11, 1, 0, 0, 32'h100000, 3'h1);
    hit(12, 1, 0, 0, 32'h100000, 3'h2);
    hit(13, 1, 0, 0, 32'h100000, 3'h0);
    chk({16'h0, la}, 32'h1234);
    chk({24'h0, ld}, 32'h5a);
    @(posedge clk) tail <= 8'hff;
    cnt <= 16'h0007;
    hit(13, 1, 0, 0, 32'h0, 3'h0);
    hit(14, 1, 0, 0, 32'h200000, 3'h0);
    chk({16'h0, la}, 32'h7);
    for (int i = 0; i < 5; i++) fire(16, 1, 0, 0);
    fire(17, 1, 0, 0);
    for (int i = 0; i < 5; i++) fire(16, 1, 0, 0);
    chk(ev, 32'h0);
    hit(16, 1, 0, 0, 32'h400000, 3'h0);
    for (int i = 0; i < 7; i++) fire(1, 0, 0, 0);
    chk(ev, 32'h0);
    hit(1, 0, 0, 0, 32'h40, 3'h0);
    $display("boot and count sources done");
    sw(1'b0, 1'b0, 1'b1, 1'b0, 32'h20);
    sw(1'b0, 1'b0, 1'b0, 1'b1, 32'h0);
    chk(nw, 32'h0);
    chk(sn, 32'h20);
    chk(ev, 32'h20);
    sw(1'b0, 1'b1, 1'b0, 1'b0, '1);
    chk(ev, 32'h0);
    sw(1'b0, 1'b0, 1'b1, 1'b0, '1);
    chk(ev, IMPL_MASK);
    @(posedge clk) req <= 18'h200;
    @(posedge clk) req <= '0;
    ec <= 1'b1;
    wd <= '1;
    @(posedge clk) ec <= 1'b0;
    #1 chk(ev, 32'h20000);
    sw(1'b1, 1'b0, 1'b0, 1'b0, '1);
    sw(1'b0, 1'b0, 1'b1, 1'b0, '1);
    @(posedge clk) srst <= 1'b1;
    fire(9, 0, 0, 0);
    chk(ev, 32'h0);
    @(posedge clk) srst <= 1'b0;
    $display("software access done");
    end_sim();
  end
endmodule
